// ===== hw/pmx_pin_select.sv
// pin function select register and the pin steering behind it
// assumes peripherals present per-lane out/oe and pad logic resolves pins
`timescale 1ns/1ps

// How it works
// - bits 14:12 pick parallel port grouping
// - mode 0: all 21 lcd lanes
// - mode 1: spi, 6 gpio, uart, audio 2
// - mode 2: 8-bit lcd plus 8 gpio
// - mode 3: 8-bit lcd, spi, audio 3
// - mode 4: 8-bit lcd, audio 2, uart
// - mode 5: 8-bit lcd, spi, uart
// - mode 6: spi, audio 2, audio 3, gpio
// - bits 11:10 pick serial port 1 use
// - serial 1 code 00: card port 1
// - serial 1 code 01: audio 1, gpio 11:10
// - serial 1 code 10: gpio 11:6
// - bits 9:8 pick serial port 0 use
// - serial 0 code 00: card port 0
// - serial 0 code 01: audio 0, gpio 5:4
// - serial 0 code 10: gpio 5:0
// - bits 7:6 reserved, read zero, ignore writes
// - bit 5: address 20 or gpio 26
// - bit 4: address 19 or gpio 25
// - bit 3: address 18 or gpio 24
// - bits 2:0: address 17:15 or gpio 23:21
module pmx_pin_select (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire pmx_pkg::pmx_bus_t i_bus,
  output logic [15:0] o_rdata,
  input wire pmx_pkg::pmx_lanes_t i_lanes,
  output logic [pmx_pkg::PMX_LANES-1:0] o_lane_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] i_pin_in,
  output pmx_pkg::pmx_pins_t o_pins
);
  import pmx_pkg::*;

  // ----------------------------------------------------------------
  // lane lookup per pin
  // ----------------------------------------------------------------
  // one item per parallel pin; code 111 is undefined, so the whole
  // port stays undriven rather than guessing at a grouping
  function automatic logic [6:0] pp_lane(input logic [2:0] m, input int p);
    logic [6:0] k;
    k = LN_NONE;
    if (m <= PP_SPI_AUD_GPIO) begin
      case (p)
        // enable and low data pins: spi in the lcd-free modes
        0: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI;
            PP_SPI_AUD_GPIO: k = LN_SPI;
            default: k = LN_LCD;
          endcase
        end
        1: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI + 7'd1;
            PP_SPI_AUD_GPIO: k = LN_SPI + 7'd1;
            default: k = LN_LCD + 7'd1;
          endcase
        end
        2: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI + 7'd2;
            PP_SPI_AUD_GPIO: k = LN_SPI + 7'd2;
            default: k = LN_LCD + 7'd2;
          endcase
        end

        // lcd data 2..7 or general io 12..17
        3: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_GPIO + 7'd12;
            PP_SPI_AUD_GPIO: k = LN_GPIO + 7'd12;
            default: k = LN_LCD + 7'd3;
          endcase
        end
        4: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_GPIO + 7'd13;
            PP_SPI_AUD_GPIO: k = LN_GPIO + 7'd13;
            default: k = LN_LCD + 7'd4;
          endcase
        end
        5: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_GPIO + 7'd14;
            PP_SPI_AUD_GPIO: k = LN_GPIO + 7'd14;
            default: k = LN_LCD + 7'd5;
          endcase
        end
        6: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_GPIO + 7'd15;
            PP_SPI_AUD_GPIO: k = LN_GPIO + 7'd15;
            default: k = LN_LCD + 7'd6;
          endcase
        end
        7: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_GPIO + 7'd16;
            PP_SPI_AUD_GPIO: k = LN_GPIO + 7'd16;
            default: k = LN_LCD + 7'd7;
          endcase
        end
        8: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_GPIO + 7'd17;
            PP_SPI_AUD_GPIO: k = LN_GPIO + 7'd17;
            default: k = LN_LCD + 7'd8;
          endcase
        end

        // lcd data 8..11: spi takes clock, cs0, rx, tx in pin order
        9: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_AUD2;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd18;
            PP_LCD8_SPI_AUD3: k = LN_SPI;
            PP_LCD8_AUD2_UART: k = LN_AUD2;
            PP_LCD8_SPI_UART: k = LN_SPI;
            PP_SPI_AUD_GPIO: k = LN_AUD2;
            default: k = LN_LCD + 7'd9;
          endcase
        end
        10: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_AUD2 + 7'd1;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd19;
            PP_LCD8_SPI_AUD3: k = LN_SPI + 7'd3;
            PP_LCD8_AUD2_UART: k = LN_AUD2 + 7'd1;
            PP_LCD8_SPI_UART: k = LN_SPI + 7'd3;
            PP_SPI_AUD_GPIO: k = LN_AUD2 + 7'd1;
            default: k = LN_LCD + 7'd10;
          endcase
        end
        11: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_AUD2 + 7'd2;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd20;
            PP_LCD8_SPI_AUD3: k = LN_SPI + 7'd1;
            PP_LCD8_AUD2_UART: k = LN_AUD2 + 7'd2;
            PP_LCD8_SPI_UART: k = LN_SPI + 7'd1;
            PP_SPI_AUD_GPIO: k = LN_AUD2 + 7'd2;
            default: k = LN_LCD + 7'd11;
          endcase
        end
        12: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_AUD2 + 7'd3;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd27;
            PP_LCD8_SPI_AUD3: k = LN_SPI + 7'd2;
            PP_LCD8_AUD2_UART: k = LN_AUD2 + 7'd3;
            PP_LCD8_SPI_UART: k = LN_SPI + 7'd2;
            PP_SPI_AUD_GPIO: k = LN_AUD2 + 7'd3;
            default: k = LN_LCD + 7'd12;
          endcase
        end

        // lcd data 12..15: uart or audio 3, gpio 28..31 in mode 2
        13: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_UART;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd28;
            PP_LCD8_SPI_AUD3: k = LN_AUD3;
            PP_LCD8_AUD2_UART: k = LN_UART;
            PP_LCD8_SPI_UART: k = LN_UART;
            PP_SPI_AUD_GPIO: k = LN_AUD3;
            default: k = LN_LCD + 7'd13;
          endcase
        end
        14: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_UART + 7'd1;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd29;
            PP_LCD8_SPI_AUD3: k = LN_AUD3 + 7'd1;
            PP_LCD8_AUD2_UART: k = LN_UART + 7'd1;
            PP_LCD8_SPI_UART: k = LN_UART + 7'd1;
            PP_SPI_AUD_GPIO: k = LN_AUD3 + 7'd1;
            default: k = LN_LCD + 7'd14;
          endcase
        end
        15: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_UART + 7'd2;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd30;
            PP_LCD8_SPI_AUD3: k = LN_AUD3 + 7'd2;
            PP_LCD8_AUD2_UART: k = LN_UART + 7'd2;
            PP_LCD8_SPI_UART: k = LN_UART + 7'd2;
            PP_SPI_AUD_GPIO: k = LN_AUD3 + 7'd2;
            default: k = LN_LCD + 7'd15;
          endcase
        end
        16: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_UART + 7'd3;
            PP_LCD8_GPIO: k = LN_GPIO + 7'd31;
            PP_LCD8_SPI_AUD3: k = LN_AUD3 + 7'd3;
            PP_LCD8_AUD2_UART: k = LN_UART + 7'd3;
            PP_LCD8_SPI_UART: k = LN_UART + 7'd3;
            PP_SPI_AUD_GPIO: k = LN_AUD3 + 7'd3;
            default: k = LN_LCD + 7'd16;
          endcase
        end

        // lcd control pins: spi chip selects 0..3
        17: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI + 7'd3;
            PP_SPI_AUD_GPIO: k = LN_SPI + 7'd3;
            default: k = LN_LCD + 7'd17;
          endcase
        end
        18: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI + 7'd4;
            PP_SPI_AUD_GPIO: k = LN_SPI + 7'd4;
            default: k = LN_LCD + 7'd18;
          endcase
        end
        19: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI + 7'd5;
            PP_SPI_AUD_GPIO: k = LN_SPI + 7'd5;
            default: k = LN_LCD + 7'd19;
          endcase
        end
        20: begin
          case (m)
            PP_SPI_GPIO_UART: k = LN_SPI + 7'd6;
            PP_SPI_AUD_GPIO: k = LN_SPI + 7'd6;
            default: k = LN_LCD + 7'd20;
          endcase
        end
        default: k = LN_NONE;
      endcase
    end
    return k;
  endfunction : pp_lane

  // card lanes clk/cmd/d0..d3; audio on pins 0..3, gpio keeps pins 4,5
  function automatic logic [6:0] sp_lane(input logic [1:0] m, input int p,
                                         input logic [6:0] card,
                                         input logic [6:0] aud,
                                         input logic [6:0] gp);
    logic [6:0] pl;
    logic [6:0] k;
    pl = 7'(p);
    case (m)
      SP_CARD: k = card + pl;
      SP_AUDIO_GPIO: k = (p < 4) ? aud + pl : LN_GPIO + gp + pl;
      SP_GPIO: k = LN_GPIO + gp + pl;
      default: k = LN_NONE; // reserved code leaves the pins undriven
    endcase
    return k;
  endfunction : sp_lane

  // each upper address pin hands over to its own gpio line
  function automatic logic [6:0] ad_lane(input logic gp, input int p);
    logic [6:0] k;
    if (gp) begin
      k = LN_GPIO + 7'd21 + 7'(p);
    end else begin
      k = LN_EMA + 7'(p);
    end
    return k;
  endfunction : ad_lane

  // ----------------------------------------------------------------
  // selection register
  // ----------------------------------------------------------------
  logic [15:0] sel_q;
  logic [15:0] sel_d;
  logic wr_hit;

  assign wr_hit = i_bus.wr && (i_bus.addr == PMX_SEL_ADDR);

  always_comb begin
    sel_d = sel_q;
    if (wr_hit) begin
      sel_d = i_bus.wdata & PMX_SEL_WMASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sel_q <= PMX_SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  // a read returns the stored word, never one written alongside it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_bus.rd && i_bus.addr == PMX_SEL_ADDR) begin
      o_rdata <= sel_q;
    end else begin
      o_rdata <= 16'h0000; // unmapped or idle reads give zero
    end
  end

  // ----------------------------------------------------------------
  // pin to lane table, built from the next register value so a pin
  // turns over on the same edge that stores the write
  // ----------------------------------------------------------------
  logic [2:0] pp_sel;
  logic [1:0] sp1_sel;
  logic [1:0] sp0_sel;
  logic [5:0] ad_sel;
  logic [6:0] lane_of [PMX_PINS];

  assign pp_sel = sel_d[PMX_PP_MSB:PMX_PP_LSB];
  assign sp1_sel = sel_d[PMX_SP1_MSB:PMX_SP1_LSB];
  assign sp0_sel = sel_d[PMX_SP0_MSB:PMX_SP0_LSB];
  assign ad_sel = sel_d[PMX_ADDR_MSB:PMX_ADDR_LSB];

  always_comb begin
    for (int p = 0; p < PIN_SP0; p++) begin
      lane_of[p] = pp_lane(pp_sel, p);
    end
    for (int p = 0; p < 6; p++) begin
      lane_of[PIN_SP0 + p] = sp_lane(sp0_sel, p, LN_CARD0, LN_AUD0, 7'd0);
      lane_of[PIN_SP1 + p] = sp_lane(sp1_sel, p, LN_CARD1, LN_AUD1, 7'd6);
      lane_of[PIN_ADDR + p] = ad_lane(ad_sel[p], p);
    end
  end

  // ----------------------------------------------------------------
  // pin drive and input return; one flop stage to keep pads clean
  // ----------------------------------------------------------------
  logic [PMX_LANES:0] all_out;
  logic [PMX_LANES:0] all_oe;
  logic [PMX_LANES:0] all_in;
  pmx_pins_t pins_d;

  assign all_out = {1'b0, i_lanes.out};
  assign all_oe = {1'b0, i_lanes.oe};

  always_comb begin
    pins_d = '0;
    all_in = '0;
    for (int p = 0; p < PMX_PINS; p++) begin
      pins_d.out[p] = all_out[lane_of[p]];
      pins_d.oe[p] = all_oe[lane_of[p]];
      all_in[lane_of[p]] = i_pin_in[p];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pins <= '0;
    end else begin
      o_pins <= pins_d;
    end
  end

  // unselected lanes see zero, never a stale pin
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_lane_in <= '0;
    end else begin
      o_lane_in <= all_in[PMX_LANES-1:0];
    end
  end

endmodule : pmx_pin_select

// ===== include/pmx_pkg.sv
// pin function select: constants, lane map and carrier types
// assumes one system clock; lanes are the peripheral-side signals
package pmx_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PMX_SEL_ADDR = 8'h00;
  localparam logic [15:0] PMX_SEL_RESET = 16'h0000;
  // bits 15, 7 and 6 hold nothing and read as zero
  localparam logic [15:0] PMX_SEL_WMASK = 16'h7f3f;
  localparam int PMX_PP_MSB = 14;
  localparam int PMX_PP_LSB = 12;
  localparam int PMX_SP1_MSB = 11;
  localparam int PMX_SP1_LSB = 10;
  localparam int PMX_SP0_MSB = 9;
  localparam int PMX_SP0_LSB = 8;
  localparam int PMX_ADDR_MSB = 5;
  localparam int PMX_ADDR_LSB = 0;

  // ----------------------------------------------------------------
  // mode encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] PP_LCD16 = 3'h0;
  localparam logic [2:0] PP_SPI_GPIO_UART = 3'h1;
  localparam logic [2:0] PP_LCD8_GPIO = 3'h2;
  localparam logic [2:0] PP_LCD8_SPI_AUD3 = 3'h3;
  localparam logic [2:0] PP_LCD8_AUD2_UART = 3'h4;
  localparam logic [2:0] PP_LCD8_SPI_UART = 3'h5;
  localparam logic [2:0] PP_SPI_AUD_GPIO = 3'h6;
  localparam logic [1:0] SP_CARD = 2'h0;
  localparam logic [1:0] SP_AUDIO_GPIO = 2'h1;
  localparam logic [1:0] SP_GPIO = 2'h2;

  // ----------------------------------------------------------------
  // pins: parallel 0..20, serial0 21..26, serial1 27..32, addr 33..38
  // ----------------------------------------------------------------
  localparam int PMX_PINS = 39;
  localparam int PIN_SP0 = 21;
  localparam int PIN_SP1 = 27;
  localparam int PIN_ADDR = 33;

  // ----------------------------------------------------------------
  // lanes: lcd 21, spi clk/rx/tx/cs0..3, uart rts/cts/rxd/txd,
  // audio ports 0..3 clk/fs/rx/dx, card ports clk/cmd/d0..d3,
  // memory address 15..20, general io 0..31, then one dead lane
  // ----------------------------------------------------------------
  localparam int PMX_LANES = 98;
  localparam logic [6:0] LN_LCD = 7'h00;
  localparam logic [6:0] LN_SPI = 7'h15;
  localparam logic [6:0] LN_UART = 7'h1c;
  localparam logic [6:0] LN_AUD0 = 7'h20;
  localparam logic [6:0] LN_AUD1 = 7'h24;
  localparam logic [6:0] LN_AUD2 = 7'h28;
  localparam logic [6:0] LN_AUD3 = 7'h2c;
  localparam logic [6:0] LN_CARD0 = 7'h30;
  localparam logic [6:0] LN_CARD1 = 7'h36;
  localparam logic [6:0] LN_EMA = 7'h3c;
  localparam logic [6:0] LN_GPIO = 7'h42;
  localparam logic [6:0] LN_NONE = 7'h62;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pmx_bus_t;

  typedef struct packed {
    logic [PMX_LANES-1:0] out;
    logic [PMX_LANES-1:0] oe;
  } pmx_lanes_t;

  typedef struct packed {
    logic [PMX_PINS-1:0] out;
    logic [PMX_PINS-1:0] oe;
  } pmx_pins_t;

endpackage : pmx_pkg

// ===== test/pmx_pin_select_properties.sv
// port assertions for the pin function select block
// assumes it is bound to pmx_pin_select from the bench top file
`timescale 1ns/1ps
module pmx_pin_select_properties
  import pmx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire pmx_pkg::pmx_bus_t i_bus,
  input wire logic [15:0] o_rdata,
  input wire pmx_pkg::pmx_lanes_t i_lanes,
  input wire logic [pmx_pkg::PMX_LANES-1:0] o_lane_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] i_pin_in,
  input wire pmx_pkg::pmx_pins_t o_pins
);
  // shadow of the selection, next value is what steers this edge
  logic [15:0] sel_q;
  logic [15:0] sel_d;
  assign sel_d = (i_bus.wr && i_bus.addr == PMX_SEL_ADDR) ? (i_bus.wdata & PMX_SEL_WMASK) : sel_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) sel_q <= PMX_SEL_RESET;
    else sel_q <= sel_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_rd_sel;
    i_bus.rd && i_bus.addr == PMX_SEL_ADDR;
  endsequence
  a_rd_value: assert property (s_rd_sel |=> o_rdata == $past(sel_q))
    else $error("read data differs from stored selection");
  a_rsvd_zero: assert property (i_bus.rd |=> o_rdata[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  a_pp_lcd: assert property (!i_reset && sel_d[14:12] == PP_LCD16
    |=> o_pins.out[20:0] == $past(i_lanes.out[20:0])) else $error("lcd lanes not on port");
  a_pp_gpio_in: assert property (!i_reset && sel_d[14:12] == PP_LCD8_GPIO
    |=> o_lane_in[84] == $past(i_pin_in[9])) else $error("pin input not returned");
  a_pp_spi_cs: assert property (!i_reset && sel_d[14:12] == PP_SPI_AUD_GPIO
    |=> o_pins.oe[17] == $past(i_lanes.oe[24])) else $error("chip select enable lost");
  a_sp0_card: assert property (!i_reset && sel_d[9:8] == SP_CARD
    |=> o_pins.out[26:21] == $past(i_lanes.out[53:48])) else $error("card port 0 wrong");
  a_sp1_gpio: assert property (!i_reset && sel_d[11:10] == SP_GPIO
    |=> o_pins.out[32:27] == $past(i_lanes.out[77:72])) else $error("serial 1 gpio wrong");
  a_addr20_pin: assert property (!i_reset |=> o_pins.out[38] ==
    ($past(sel_d[5]) ? $past(i_lanes.out[92]) : $past(i_lanes.out[65])))
    else $error("address 20 pin wrong");
  a_addr15_pin: assert property (!i_reset |=> o_pins.out[33] ==
    ($past(sel_d[0]) ? $past(i_lanes.out[87]) : $past(i_lanes.out[60])))
    else $error("address 15 pin wrong");
endmodule : pmx_pin_select_properties

// ===== test/tb_pmx_pin_select.sv
// bench: table of selection, pin and lane rows, then reserved and reset cases
// assumes the properties file is compiled first and bound below
`timescale 1ns/1ps
module tb_pmx_pin_select;
  import pmx_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  pmx_bus_t i_bus = '0;
  pmx_lanes_t i_lanes = '1;
  logic [PMX_PINS-1:0] i_pin_in = '0;
  logic [15:0] o_rdata;
  logic [PMX_LANES-1:0] o_lane_in;
  pmx_pins_t o_pins;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // row: selection word, pin, lane that the pin must carry
  logic [31:0] rows [32] = '{32'h0000_0505, 32'h0000_1b36, 32'h0000_1530, 32'h0000_2641,
    32'h1000_0015, 32'h1000_034e, 32'h1000_0d1c, 32'h1000_0928, 32'h2000_0954,
    32'h2000_0c5d, 32'h2000_0101, 32'h3000_0915, 32'h3000_0a18, 32'h3000_0d2c,
    32'h4000_0928, 32'h4000_0d1c, 32'h5000_0b16, 32'h5000_101f, 32'h6000_1118,
    32'h6000_0d2c, 32'h6000_044f, 32'h0400_1b24, 32'h0400_1f4c, 32'h0800_1b48,
    32'h0100_1520, 32'h0100_1a47, 32'h0200_1542, 32'h0020_265c, 32'h0010_255b,
    32'h0008_245a, 32'h003f_2157, 32'h0004_2359};
  pmx_pin_select dut (.i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_lanes(i_lanes), .o_lane_in(o_lane_in), .i_pin_in(i_pin_in), .o_pins(o_pins));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [97:0] got, input logic [97:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // lanes and pads change on the write edge itself, so one cycle shows any lag
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [6:0] ln,
                    input logic [5:0] pn);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    i_lanes <= '{out: 98'(1) << ln, oe: 98'(1) << ln};
    i_pin_in <= 39'(1) << pn;
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1 check(98'(o_rdata), 98'(exp));
  endtask : rd
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (9) @(posedge i_clk);
    #1 check(98'(o_pins.oe), 98'(0));
    @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      wr(8'h00, rows[i][31:16], rows[i][6:0], rows[i][13:8]);
      check(98'(o_pins.out), 98'(39'(1) << rows[i][13:8]));
      check(98'(o_pins.oe), 98'(39'(1) << rows[i][13:8]));
      check(o_lane_in, 98'(1) << rows[i][6:0]);
    end
    // parallel code 111 idles the port; serial fields keep defined codes
    wr(8'h00, 16'hf6ff, 7'h5c, 6'h26);
    @(posedge i_clk);
    i_lanes <= '{out: '1, oe: '1};
    @(posedge i_clk);
    #1 check(98'(o_pins.oe), 98'({18'h3ffff, 21'h0}));
    check(98'(o_pins.out), 98'({18'h3ffff, 21'h0}));
    rd(8'h00, 16'h763f);
    wr(8'h01, 16'h0000, 7'h00, 6'h00);
    rd(8'h00, 16'h763f);
    rd(8'h01, 16'h0000);
    @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    rd(8'h00, 16'h0000);
    check(98'(o_pins.out), 98'(1));
    check(o_lane_in, 98'(1));
    end_of_test();
  end
endmodule : tb_pmx_pin_select
bind pmx_pin_select pmx_pin_select_properties u_props (.i_clk(i_clk), .i_reset(i_reset),
  .i_bus(i_bus), .o_rdata(o_rdata), .i_lanes(i_lanes), .o_lane_in(o_lane_in),
  .i_pin_in(i_pin_in), .o_pins(o_pins));
